// ==== logic/expander_pkg.sv ====
package expander_pkg;

  // ----------------------------------------
  // Address and command codes
  // ----------------------------------------
  localparam logic [5:0] SLAVE_ADDR_HIGH = 6'h10;
  localparam logic [1:0] SEL_INPUT = 2'h0;
  localparam logic [1:0] SEL_LATCH = 2'h1;
  localparam logic [1:0] SEL_POLARITY = 2'h2;
  localparam logic [1:0] SEL_DIRECTION = 2'h3;
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_CODE_MSB = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  // Bus lines rest high; pin and strap stages rest low
  localparam logic [10:0] SYNC_RESET = 11'h003;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } busLines_type;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] polarity;
    logic [7:0] direction;
  } portRegs_type;

endpackage

// ==== logic/two_flop_sync.sv ====
`timescale 1ns/10ps
module two_flop_sync #(
  parameter int WIDTH = 11,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // Stage one feeds only stage two
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ==== logic/pin_driver_bank.sv ====
`timescale 1ns/10ps
module pin_driver_bank #(
  parameter int PINS = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register view
  input wire expander_pkg::portRegs_type regs,
  // Pins
  output logic [PINS-1:0] portOut,
  output logic [PINS-1:0] portOe
);
  import expander_pkg::*;

  // ----------------------------------------
  // One driver per pin
  // ----------------------------------------
  for (genvar i = 0; i < PINS; i++) begin : gPin
    logic next_out;
    logic next_oe;
    always_comb begin
      next_out = regs.latch[i];
      next_oe = ~regs.direction[i];
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        portOut[i] <= LATCH_RESET[i];
        portOe[i] <= ~DIRECTION_RESET[i];
      end else begin
        portOut[i] <= next_out;
        portOe[i] <= next_oe;
      end
    end
  end

endmodule

// ==== logic/i2c_eight_bit_port_expander_regs.sv ====
`timescale 1ns/10ps
module i2c_eight_bit_port_expander_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial bus
  input wire expander_pkg::busLines_type busIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address select strap
  input wire logic addrSel,
  // Port pins
  input wire logic [7:0] portIn,
  output logic [7:0] portOut,
  output logic [7:0] portOe
);
  import expander_pkg::*;

  // ----------------------------------------
  // Types and functions
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACKADDR = 9'h004,
    ST_CMD = 9'h008,
    ST_DATA = 9'h010,
    ST_ACKWR = 9'h020,
    ST_TX = 9'h040,
    ST_MACK = 9'h080,
    ST_SKIP = 9'h100
  } busState_type;

  function automatic logic codeValid(input logic [7:0] code);
    codeValid = (code[7:SEL_CODE_MSB+1] == '0);
  endfunction

  // ----------------------------------------
  // Input synchronisers and edge detect
  // ----------------------------------------
  logic [10:0] syncVec;
  logic sclS;
  logic sdaS;
  logic addrS;
  logic [7:0] pinS;
  logic sclPrev;
  logic sdaPrev;
  logic next_sclPrev;
  logic next_sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // Stages rest at the idle bus level so no false edge follows reset
  two_flop_sync #(
    .WIDTH(11),
    .RESET_VALUE(SYNC_RESET)
  ) uSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .asyncIn({portIn, addrSel, busIn.sda, busIn.scl}),
    .syncOut(syncVec)
  );

  assign sclS = syncVec[0];
  assign sdaS = syncVec[1];
  assign addrS = syncVec[2];
  assign pinS = syncVec[10:3];

  always_comb begin
    next_sclPrev = sclS;
    next_sdaPrev = sdaS;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclPrev <= SYNC_RESET[0];
      sdaPrev <= SYNC_RESET[1];
    end else begin
      sclPrev <= next_sclPrev;
      sdaPrev <= next_sdaPrev;
    end
  end

  assign sclRise = sclS & ~sclPrev;
  assign sclFall = ~sclS & sclPrev;
  assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  portRegs_type regs;
  portRegs_type next_regs;
  logic [7:0] select;
  logic [7:0] next_select;
  logic [7:0] inputLevels;
  logic [7:0] next_inputLevels;
  logic [7:0] readValue;
  logic wrEn;
  logic selWr;
  logic [7:0] shift;

  always_comb begin
    // Inversion only on pins set as inputs
    next_inputLevels = pinS ^ (regs.polarity & regs.direction);
    next_regs = regs;
    next_select = select;
    if (selWr) begin
      next_select = shift;
    end
    if (wrEn && codeValid(select)) begin
      unique case (select[SEL_CODE_MSB:SEL_CODE_LSB])
        SEL_INPUT: next_regs = regs;
        SEL_LATCH: next_regs.latch = shift;
        SEL_POLARITY: next_regs.polarity = shift;
        SEL_DIRECTION: next_regs.direction = shift;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regs.latch <= LATCH_RESET;
      regs.polarity <= POLARITY_RESET;
      regs.direction <= DIRECTION_RESET;
      select <= SELECT_RESET;
      inputLevels <= '0;
    end else begin
      regs <= next_regs;
      select <= next_select;
      inputLevels <= next_inputLevels;
    end
  end

  // Undefined codes read back the select register itself
  always_comb begin
    readValue = select;
    if (codeValid(select)) begin
      unique case (select[SEL_CODE_MSB:SEL_CODE_LSB])
        SEL_INPUT: readValue = inputLevels;
        SEL_LATCH: readValue = regs.latch;
        SEL_POLARITY: readValue = regs.polarity;
        SEL_DIRECTION: readValue = regs.direction;
      endcase
    end
  end

  // ----------------------------------------
  // Serial bus state machine
  // ----------------------------------------
  busState_type state;
  busState_type next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic byteDone;
  logic next_byteDone;
  logic [7:0] next_shift;
  logic [7:0] txShift;
  logic [7:0] next_txShift;
  logic rw;
  logic next_rw;
  logic ackSeen;
  logic next_ackSeen;
  logic next_sdaOe;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_byteDone = byteDone;
    next_shift = shift;
    next_txShift = txShift;
    next_rw = rw;
    next_ackSeen = ackSeen;
    next_sdaOe = sdaOe;
    wrEn = 1'b0;
    selWr = 1'b0;
    if (startSeen) begin
      next_state = ST_ADDR;
      next_cnt = '0;
      next_byteDone = 1'b0;
      next_sdaOe = 1'b0;
    end else if (stopSeen) begin
      next_state = ST_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
          next_sdaOe = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (sclRise && !byteDone) begin
            next_shift = {shift[6:0], sdaS};
            next_cnt = 3'(cnt + 3'h1);
            next_byteDone = (cnt == LAST_BIT);
          end else if (sclFall && byteDone) begin
            next_byteDone = 1'b0;
            next_cnt = '0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == {SLAVE_ADDR_HIGH, addrS}) begin
                next_rw = shift[0];
                next_state = ST_ACKADDR;
                next_sdaOe = 1'b1;
              end else begin
                next_state = ST_SKIP;
              end
            end else if (state == ST_CMD) begin
              selWr = 1'b1;
              next_state = ST_ACKWR;
              next_sdaOe = 1'b1;
            end else begin
              wrEn = 1'b1;
              next_state = ST_ACKWR;
              next_sdaOe = 1'b1;
            end
          end
        end
        ST_ACKADDR: begin
          if (sclFall) begin
            if (rw) begin
              next_txShift = readValue;
              next_sdaOe = ~readValue[7];
              next_state = ST_TX;
            end else begin
              next_sdaOe = 1'b0;
              next_state = ST_CMD;
            end
          end
        end
        ST_ACKWR: begin
          if (sclFall) begin
            next_sdaOe = 1'b0;
            next_state = ST_DATA;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (cnt == LAST_BIT) begin
              next_cnt = '0;
              next_sdaOe = 1'b0;
              next_state = ST_MACK;
            end else begin
              next_txShift = {txShift[6:0], 1'b0};
              next_sdaOe = ~txShift[6];
              next_cnt = 3'(cnt + 3'h1);
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            next_ackSeen = ~sdaS;
          end else if (sclFall) begin
            if (ackSeen) begin
              next_txShift = readValue;
              next_sdaOe = ~readValue[7];
              next_state = ST_TX;
            end else begin
              next_sdaOe = 1'b0;
              next_state = ST_SKIP;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= '0;
      byteDone <= 1'b0;
      shift <= '0;
      txShift <= '0;
      rw <= 1'b0;
      ackSeen <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      byteDone <= next_byteDone;
      shift <= next_shift;
      txShift <= next_txShift;
      rw <= next_rw;
      ackSeen <= next_ackSeen;
      sdaOe <= next_sdaOe;
      // Open drain: only ever pulls low
      sdaOut <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  pin_driver_bank #(.PINS(8)) uPins (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .regs(regs),
    .portOut(portOut),
    .portOe(portOe)
  );

endmodule

// ==== dv/expander_asserts.sv ====
`timescale 1ns/10ps
module expander_asserts (
  // Clock, reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bus
  input wire expander_pkg::busLines_type busIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Pins
  input wire logic [7:0] portOut,
  input wire logic [7:0] portOe
);
  import expander_pkg::*;
  logic prevScl;
  logic [3:0] age;
  logic [3:0] next_age;
  // ----
  // Age since clock fall
  // ----
  // Saturates so a long idle never wraps back into a legal window
  always_comb begin
    next_age = (age == 4'hf) ? age : age + 4'h1;
    if (prevScl && !busIn.scl) begin
      next_age = 4'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prevScl <= 1'b1;
      age <= 4'hf;
    end else begin
      prevScl <= busIn.scl;
      age <= next_age;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----
  // Checks
  // ----
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  sda_steady_high_a: assert property (
    busIn.scl && $past(busIn.scl) |-> $stable(sdaOe))
    else $error("data moved while clock high");
  sda_move_late_a: assert property (
    $changed(sdaOe) |-> age <= 4'h7)
    else $error("data moved far from clock fall");
  bus_freed_idle_a: assert property (
    age == 4'hf |-> !sdaOe)
    else $error("data line held on idle bus");
  ack_when_low_a: assert property (
    $rose(sdaOe) |-> !busIn.scl)
    else $error("acknowledge began with clock high");
  latch_move_late_a: assert property (
    $changed(portOut) |-> age <= 4'h7)
    else $error("pin data moved outside a byte end");
  dir_move_late_a: assert property (
    $changed(portOe) |-> age <= 4'h7)
    else $error("pin enable moved outside a byte end");
  reset_defaults_a: assert property (
    $rose(rstn) |-> portOut == 8'hff && portOe == 8'h00)
    else $error("pins not at defaults after reset");
endmodule

bind i2c_eight_bit_port_expander_regs expander_asserts u_expander_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .busIn(busIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .portOut(portOut), .portOe(portOe));

// ==== dv/bus_master.sv ====
`timescale 1ns/10ps
module bus_master (
  // Clock
  input wire logic clk_sys,
  // Device drive
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Wire levels
  output expander_pkg::busLines_type busOut
);
  import expander_pkg::*;
  logic mScl = 1'b1;
  logic mSda = 1'b1;
  // Pull-up wire: low while either party pulls
  assign busOut = '{scl: mScl, sda: mSda & ~(sdaOe & ~sdaOut)};
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Waits out the device's late release before raising the clock
  task automatic start();
    tick(1);
    mSda = 1'b1;
    tick(4);
    mScl = 1'b1;
    tick(2);
    mSda = 1'b0;
    tick(2);
    mScl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    mSda = 1'b0;
    tick(4);
    mScl = 1'b1;
    tick(2);
    mSda = 1'b1;
    tick(4);
  endtask
  // Data set one cycle after the fall, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    tick(1);
    mSda = b;
    tick(4);
    mScl = 1'b1;
    tick(2);
    r = busOut.sda;
    tick(1);
    mScl = 1'b0;
  endtask
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
  endtask
endmodule

// ==== dv/i2c_eight_bit_port_expander_regs_bench.sv ====
`timescale 1ns/10ps
module i2c_eight_bit_port_expander_regs_bench;
  import expander_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic addrSel = 1'b0;
  logic [7:0] portIn = 8'h00;
  logic sdaOut;
  logic sdaOe;
  logic [7:0] portOut;
  logic [7:0] portOe;
  busLines_type busIn;
  int fail_count = 0;
  int checked = 0;
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  i2c_eight_bit_port_expander_regs u_i2c_eight_bit_port_expander_regs (
    .clk_sys(clk_sys), .rstn(rstn), .busIn(busIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrSel(addrSel), .portIn(portIn),
    .portOut(portOut), .portOe(portOe));
  bus_master u_bus_master (.clk_sys(clk_sys), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .busOut(busIn));
  task automatic final_report();
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] adr(input logic rw);
    return {SLAVE_ADDR_HIGH, addrSel, rw, 1'b1};
  endfunction
  task automatic xb(input logic [8:0] d, input logic [8:0] exp);
    logic [8:0] r;
    u_bus_master.xbyte(d, r);
    check(r, exp);
  endtask
  task automatic head(input logic [7:0] cmd);
    u_bus_master.start();
    xb(adr(1'b0), adr(1'b0) ^ 9'h001);
    xb({cmd, 1'b1}, {cmd, 1'b0});
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    head(cmd);
    xb({d, 1'b1}, {d, 1'b0});
    u_bus_master.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e,
                    input logic fresh);
    if (fresh) begin
      head(cmd);
    end
    u_bus_master.start();
    xb(adr(1'b1), adr(1'b1) ^ 9'h001);
    xb(9'h1ff, {e, 1'b1});
    u_bus_master.stop();
  endtask
  task automatic s_reset();
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(portOut, 8'hff);
    check(portOe, 8'h00);
    rd(8'h01, 8'hff, 1'b1);
    rd(8'h02, 8'h00, 1'b1);
    rd(8'h03, 8'hff, 1'b1);
  endtask
  task automatic s_regs();
    wr(8'h03, 8'hf0);
    wr(8'h01, 8'h5a);
    wr(8'h02, 8'hcc);
    check(portOe, 8'h0f);
    check(portOut, 8'h5a);
    rd(8'h01, 8'h5a, 1'b1);
    rd(8'h02, 8'hcc, 1'b1);
    rd(8'h03, 8'hf0, 1'b1);
  endtask
  task automatic s_input();
    portIn = 8'h3c;
    rd(8'h00, 8'hfc, 1'b1);
    portIn = 8'h81;
    rd(8'h00, 8'h41, 1'b0);
  endtask
  task automatic s_ignore();
    wr(8'h00, 8'h00);
    check(portOe, 8'h0f);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h05, 1'b1);
    rd(8'h01, 8'h5a, 1'b1);
  endtask
  task automatic s_addr();
    addrSel = 1'b1;
    u_bus_master.start();
    xb(9'h081, 9'h081);
    xb(9'h003, 9'h003);
    u_bus_master.stop();
    rd(8'h01, 8'h5a, 1'b1);
    addrSel = 1'b0;
  endtask
  task automatic s_burst();
    head(8'h01);
    xb(9'h023, 9'h022);
    xb(9'h045, 9'h044);
    u_bus_master.stop();
    check(portOut, 8'h22);
    head(8'h01);
    u_bus_master.stop();
    check(portOut, 8'h22);
    head(8'h01);
    u_bus_master.start();
    xb(adr(1'b1), adr(1'b1) ^ 9'h001);
    xb(9'h1fe, 9'h044);
    xb(9'h1ff, 9'h045);
    u_bus_master.stop();
  endtask
  initial begin
    s_reset();
    s_regs();
    s_input();
    s_ignore();
    s_addr();
    s_burst();
    s_reset();
    final_report();
  end
  // Cuts a hung bus short
  initial begin
    #5000000;
    fail_count++;
    final_report();
  end
endmodule
